// ==== include/fcr_pkg.sv ====
// Package for the smart-fuse control register bank: command codes, reset values, field limits.
// Assumes a bus front end that delivers decoded register commands one at a time.
package fcr_pkg;
    // Command codes of the registers held in this bank.
    localparam logic [7:0] CMD_OUTPUT_ON_OFF_CONTROL = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_SOURCE_CONFIG = 8'h02;
    localparam logic [7:0] CMD_WRITE_PROTECTION_LEVEL = 8'h10;
    localparam logic [7:0] CMD_ALERT_MASK_SELECT = 8'h1B;
    localparam logic [7:0] CMD_CURRENT_CALIBRATION_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OVERTEMP_FAULT_THRESHOLD = 8'h4F;
    // Status register codes that a mask write may target.
    localparam logic [7:0] ST_BYTE = 8'h78;
    localparam logic [7:0] ST_WORD = 8'h79;
    localparam logic [7:0] ST_IOUT = 8'h7B;
    localparam logic [7:0] ST_INPUT = 8'h7C;
    localparam logic [7:0] ST_TEMP = 8'h7D;
    localparam logic [7:0] ST_CML = 8'h7E;
    localparam logic [7:0] ST_MFR = 8'h80;
    // Mask bits that name unsupported status functions, per target.
    localparam logic [7:0] UNSUP_BYTE = 8'h20;
    localparam logic [7:0] UNSUP_WORD = 8'h87;
    localparam logic [7:0] UNSUP_IOUT = 8'h3F;
    localparam logic [7:0] UNSUP_INPUT = 8'h0F;
    localparam logic [7:0] UNSUP_TEMP = 8'h3F;
    localparam logic [7:0] UNSUP_CML = 8'h17;
    localparam logic [7:0] UNSUP_MFR = 8'h08;
    // Live bits that never take a mask: off in the byte, power-good in the word high byte.
    localparam logic [7:0] LIVE_BYTE = 8'h40;
    localparam logic [7:0] LIVE_WORD = 8'h08;
    // Field positions.
    localparam int RUN_BIT = 7;
    localparam int CMD_EN_BIT = 3;
    localparam int PIN_EN_BIT = 2;
    localparam int SB_TEMP_BIT = 2;
    localparam int SB_CML_BIT = 1;
    localparam int CML_INV_DATA_BIT = 6;
    localparam int TEMP_OT_FAULT_BIT = 7;
    // Fixed read-as-one configuration bits (4, 1 and 0).
    localparam logic [7:0] CFG_FIXED_ONES = 8'h13;
    // Write-protect encodings in bits 7:5.
    localparam logic [2:0] WP_ALL = 3'h0;
    localparam logic [2:0] WP_CFG = 3'h1;
    localparam logic [2:0] WP_OP = 3'h2;
    localparam logic [2:0] WP_SELF = 3'h4;
    // Reset values.
    localparam logic [7:0] RST_OPERATION = 8'h00;
    localparam logic [1:0] RST_SOURCE = 2'h1;
    localparam logic [15:0] RST_CAL_OFFSET = 16'hE800;
    localparam logic [15:0] RST_OT_FAULT = 16'hF918;
    // Linear-format exponents and ranges (mantissa LSB: 0.125 A, 0.5 degree).
    localparam logic [4:0] CAL_EXP = 5'h1D;
    localparam logic signed [10:0] CAL_MANT_MAX = 11'sh010;
    localparam logic [4:0] OT_EXP = 5'h1F;
    localparam logic [10:0] OT_MANT_MIN = 11'h0A0;
    localparam logic [10:0] OT_MANT_MAX = 11'h12C;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } fcr_cmd_t;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } fcr_resp_t;
endpackage : fcr_pkg

// ==== rtl/fcr_bank.sv ====
// Control register bank of the smart fuse: on/off control, write protection, alert masks,
// current calibration offset and over-temperature fault limit.
// Assumes a bus front end that decodes each command into one cycle of fcr_cmd_t, and
// measurement inputs that are synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none

module fcr_bank #(
    parameter int MEAS_W = 11
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire fcr_pkg::fcr_cmd_t i_cmd,
    input wire logic i_clear_faults,
    input wire logic i_enable_pin,
    input wire logic [10:0] i_temp_half_deg,
    input wire logic [10:0] i_ot_warn_mant,
    input wire logic signed [MEAS_W-1:0] i_iout_raw,
    output fcr_pkg::fcr_resp_t o_resp,
    output logic o_output_on,
    output logic o_alert_n,
    output logic [7:0] o_status_byte,
    output logic [7:0] o_status_cml,
    output logic [7:0] o_status_temp,
    output logic signed [MEAS_W:0] o_iout_corrected
);
    typedef enum logic [2:0] {
        FCR_IDX_BYTE,
        FCR_IDX_WORD,
        FCR_IDX_IOUT,
        FCR_IDX_INPUT,
        FCR_IDX_TEMP,
        FCR_IDX_CML,
        FCR_IDX_MFR,
        FCR_IDX_NONE
    } fcr_mask_idx_t;

    logic output_run_bit_r;
    logic command_enable_select_r;
    logic pin_enable_select_r;
    logic [2:0] wp_level_r;
    logic [15:0] cal_offset_r;
    logic [15:0] overtemp_fault_value_r;
    logic [7:0] mask_r [0:6];
    logic cml_flag_r;
    logic inv_data_flag_r;
    logic temp_flag_r;
    logic ot_fault_flag_r;

    logic wr;
    logic [7:0] wr_lo;
    logic [7:0] wr_hi;
    logic wp_allows;
    logic data_ok;
    logic accept;
    logic reject;
    fcr_mask_idx_t mask_idx;
    logic [7:0] mask_unsup;
    logic [7:0] mask_live;
    logic signed [10:0] cal_mant;
    logic [10:0] ot_mant;
    logic ot_hit;
    logic run_req;

    assign wr = i_cmd.valid && i_cmd.write;
    assign wr_lo = i_cmd.data[7:0];
    assign wr_hi = i_cmd.data[15:8];
    assign cal_mant = i_cmd.data[10:0];
    assign ot_mant = i_cmd.data[10:0];

    // Write protection gates writes only; reads never consult it.
    always_comb begin
        case (wp_level_r)
            fcr_pkg::WP_ALL: wp_allows = 1'b1;
            fcr_pkg::WP_CFG: wp_allows = (i_cmd.code == fcr_pkg::CMD_WRITE_PROTECTION_LEVEL)
                || (i_cmd.code == fcr_pkg::CMD_OUTPUT_ON_OFF_CONTROL)
                || (i_cmd.code == fcr_pkg::CMD_ON_OFF_SOURCE_CONFIG);
            fcr_pkg::WP_OP: wp_allows = (i_cmd.code == fcr_pkg::CMD_WRITE_PROTECTION_LEVEL)
                || (i_cmd.code == fcr_pkg::CMD_OUTPUT_ON_OFF_CONTROL);
            default: wp_allows = (i_cmd.code == fcr_pkg::CMD_WRITE_PROTECTION_LEVEL);
        endcase
    end

    // Mask targets; the status word low byte has no entry of its own.
    always_comb begin
        case (wr_lo)
            fcr_pkg::ST_BYTE: mask_idx = FCR_IDX_BYTE;
            fcr_pkg::ST_WORD: mask_idx = FCR_IDX_WORD;
            fcr_pkg::ST_IOUT: mask_idx = FCR_IDX_IOUT;
            fcr_pkg::ST_INPUT: mask_idx = FCR_IDX_INPUT;
            fcr_pkg::ST_TEMP: mask_idx = FCR_IDX_TEMP;
            fcr_pkg::ST_CML: mask_idx = FCR_IDX_CML;
            fcr_pkg::ST_MFR: mask_idx = FCR_IDX_MFR;
            default: mask_idx = FCR_IDX_NONE;
        endcase
    end

    always_comb begin
        mask_live = 8'h00;
        case (mask_idx)
            FCR_IDX_BYTE: begin
                mask_unsup = fcr_pkg::UNSUP_BYTE;
                mask_live = fcr_pkg::LIVE_BYTE;
            end
            FCR_IDX_WORD: begin
                mask_unsup = fcr_pkg::UNSUP_WORD;
                mask_live = fcr_pkg::LIVE_WORD;
            end
            FCR_IDX_IOUT: mask_unsup = fcr_pkg::UNSUP_IOUT;
            FCR_IDX_INPUT: mask_unsup = fcr_pkg::UNSUP_INPUT;
            FCR_IDX_TEMP: mask_unsup = fcr_pkg::UNSUP_TEMP;
            FCR_IDX_CML: mask_unsup = fcr_pkg::UNSUP_CML;
            FCR_IDX_MFR: mask_unsup = fcr_pkg::UNSUP_MFR;
            default: mask_unsup = 8'hFF;
        endcase
    end

    // Content check per register; anything not listed is accepted as data.
    always_comb begin
        case (i_cmd.code)
            fcr_pkg::CMD_ON_OFF_SOURCE_CONFIG:
                data_ok = ((wr_lo & fcr_pkg::CFG_FIXED_ONES) == fcr_pkg::CFG_FIXED_ONES);
            fcr_pkg::CMD_WRITE_PROTECTION_LEVEL:
                data_ok = (wr_lo[7:5] == fcr_pkg::WP_ALL) || (wr_lo[7:5] == fcr_pkg::WP_CFG)
                    || (wr_lo[7:5] == fcr_pkg::WP_OP)
                    || (wr_lo[7:5] == fcr_pkg::WP_SELF);
            fcr_pkg::CMD_ALERT_MASK_SELECT:
                data_ok = (mask_idx != FCR_IDX_NONE) && ((wr_hi & mask_unsup) == 8'h00);
            fcr_pkg::CMD_CURRENT_CALIBRATION_OFFSET:
                data_ok = (i_cmd.data[15:11] == fcr_pkg::CAL_EXP)
                    && (cal_mant <= fcr_pkg::CAL_MANT_MAX)
                    && (cal_mant >= -fcr_pkg::CAL_MANT_MAX);
            fcr_pkg::CMD_OVERTEMP_FAULT_THRESHOLD:
                data_ok = (i_cmd.data[15:11] == fcr_pkg::OT_EXP)
                    && (ot_mant >= fcr_pkg::OT_MANT_MIN)
                    && (ot_mant <= fcr_pkg::OT_MANT_MAX)
                    && (ot_mant > i_ot_warn_mant);
            default: data_ok = 1'b1;
        endcase
    end

    // A write refused by protection takes the same invalid-data path as bad content.
    assign accept = wr && wp_allows && data_ok;
    assign reject = wr && !(wp_allows && data_ok);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            output_run_bit_r <= fcr_pkg::RST_OPERATION[fcr_pkg::RUN_BIT];
        end else if (accept && i_cmd.code == fcr_pkg::CMD_OUTPUT_ON_OFF_CONTROL) begin
            output_run_bit_r <= wr_lo[fcr_pkg::RUN_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            {command_enable_select_r, pin_enable_select_r} <= fcr_pkg::RST_SOURCE;
        end else if (accept && i_cmd.code == fcr_pkg::CMD_ON_OFF_SOURCE_CONFIG) begin
            command_enable_select_r <= wr_lo[fcr_pkg::CMD_EN_BIT];
            pin_enable_select_r <= wr_lo[fcr_pkg::PIN_EN_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wp_level_r <= fcr_pkg::WP_ALL;
        end else if (accept && i_cmd.code == fcr_pkg::CMD_WRITE_PROTECTION_LEVEL) begin
            wp_level_r <= wr_lo[7:5];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cal_offset_r <= fcr_pkg::RST_CAL_OFFSET;
        end else if (accept && i_cmd.code == fcr_pkg::CMD_CURRENT_CALIBRATION_OFFSET) begin
            cal_offset_r <= i_cmd.data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            overtemp_fault_value_r <= fcr_pkg::RST_OT_FAULT;
        end else if (accept && i_cmd.code == fcr_pkg::CMD_OVERTEMP_FAULT_THRESHOLD) begin
            overtemp_fault_value_r <= i_cmd.data;
        end
    end

    // Live bits keep their old mask value, so a write aimed at them changes nothing.
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_mask
            always_ff @(posedge i_clock) begin
                if (i_sys_rst) begin
                    mask_r[gi] <= 8'h00;
                end else if (accept && i_cmd.code == fcr_pkg::CMD_ALERT_MASK_SELECT
                        && mask_idx == fcr_mask_idx_t'(gi)) begin
                    mask_r[gi] <= (wr_hi & ~mask_live) | (mask_r[gi] & mask_live);
                end
            end
        end
    endgenerate

    // Sticky flags: a new event in the clearing cycle wins.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cml_flag_r <= 1'b0;
            inv_data_flag_r <= 1'b0;
        end else if (reject) begin
            cml_flag_r <= 1'b1;
            inv_data_flag_r <= 1'b1;
        end else if (i_clear_faults) begin
            cml_flag_r <= 1'b0;
            inv_data_flag_r <= 1'b0;
        end
    end

    assign ot_hit = (i_temp_half_deg >= overtemp_fault_value_r[10:0]);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            temp_flag_r <= 1'b0;
            ot_fault_flag_r <= 1'b0;
        end else if (ot_hit) begin
            temp_flag_r <= 1'b1;
            ot_fault_flag_r <= 1'b1;
        end else if (i_clear_faults) begin
            temp_flag_r <= 1'b0;
            ot_fault_flag_r <= 1'b0;
        end
    end

    // Source selection; with both enables clear nothing can start the output.
    always_comb begin
        case ({command_enable_select_r, pin_enable_select_r})
            2'b10: run_req = output_run_bit_r;
            2'b11: run_req = output_run_bit_r && i_enable_pin;
            2'b01: run_req = i_enable_pin;
            default: run_req = 1'b0;
        endcase
    end

    // The fault latch shuts the output whatever the masks say.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_output_on <= 1'b0;
        end else begin
            o_output_on <= run_req && !ot_hit && !ot_fault_flag_r;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_iout_corrected <= '0;
        end else begin
            o_iout_corrected <= (MEAS_W+1)'(i_iout_raw)
                + (MEAS_W+1)'($signed(cal_offset_r[10:0]));
        end
    end

    // The alert sees the masks; the off bit is live and never drives it.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_alert_n <= 1'b1;
        end else begin
            o_alert_n <= !((cml_flag_r && !mask_r[FCR_IDX_BYTE][fcr_pkg::SB_CML_BIT])
                || (inv_data_flag_r && !mask_r[FCR_IDX_CML][fcr_pkg::CML_INV_DATA_BIT])
                || (temp_flag_r && !mask_r[FCR_IDX_BYTE][fcr_pkg::SB_TEMP_BIT])
                || (ot_fault_flag_r
                    && !mask_r[FCR_IDX_TEMP][fcr_pkg::TEMP_OT_FAULT_BIT]));
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_status_byte <= 8'h00;
            o_status_cml <= 8'h00;
            o_status_temp <= 8'h00;
        end else begin
            o_status_byte <= {1'b0, !o_output_on, 3'b000, temp_flag_r, cml_flag_r, 1'b0};
            o_status_cml <= {1'b0, inv_data_flag_r, 6'h00};
            o_status_temp <= {ot_fault_flag_r, 7'h00};
        end
    end

    // Responses: one cycle after each command; reads ignore the protection level.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_resp <= '0;
        end else begin
            o_resp.valid <= i_cmd.valid;
            o_resp.nack <= reject;
            o_resp.data <= 16'h0000;
            if (i_cmd.valid && !i_cmd.write) begin
                case (i_cmd.code)
                    fcr_pkg::CMD_OUTPUT_ON_OFF_CONTROL:
                        o_resp.data <= {8'h00, output_run_bit_r, 7'h00};
                    fcr_pkg::CMD_ON_OFF_SOURCE_CONFIG:
                        o_resp.data <= {8'h00, 3'b000, 1'b1, command_enable_select_r,
                            pin_enable_select_r, 2'b11};
                    fcr_pkg::CMD_WRITE_PROTECTION_LEVEL:
                        o_resp.data <= {8'h00, wp_level_r, 5'h00};
                    fcr_pkg::CMD_CURRENT_CALIBRATION_OFFSET:
                        o_resp.data <= cal_offset_r;
                    fcr_pkg::CMD_OVERTEMP_FAULT_THRESHOLD:
                        o_resp.data <= overtemp_fault_value_r;
                    default: o_resp.nack <= 1'b1;
                endcase
            end
        end
    end
endmodule : fcr_bank

`default_nettype wire

// ==== testbench/fcr_host.sv ====
// Host-side model that issues one decoded command at a time and collects the response.
// Assumes the bank answers every command exactly one cycle after it is taken.
`timescale 1ns/1ps
`default_nettype none
module fcr_host (
    input wire logic i_clock,
    input wire fcr_pkg::fcr_resp_t i_resp,
    output var fcr_pkg::fcr_cmd_t o_cmd
);
    initial o_cmd = '0;
    // The target status code goes first, in the low byte, and the mask byte follows it.
    function automatic logic [15:0] mask_word(input logic [7:0] target, input logic [7:0] mask);
        return {mask, target};
    endfunction : mask_word
    // A request stands for exactly one edge, so back-to-back calls never stretch a pulse.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ok, output logic nack, output logic [15:0] rdata);
        @(posedge i_clock);
        o_cmd <= '{valid: 1'h1, write: wr, code: code, data: data};
        @(posedge i_clock);
        o_cmd <= '0;
        #1;
        ok = i_resp.valid;
        nack = i_resp.nack;
        rdata = i_resp.data;
        // The response stands one cycle only; the extra edge lets status outputs settle.
        @(posedge i_clock);
        #1;
    endtask : xfer
endmodule : fcr_host
`default_nettype wire

// ==== testbench/fcr_bank_asserts.sv ====
// Checker for the fuse control register bank: refusals, read values and status relations.
// Assumes it is bound to fcr_bank and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fcr_bank_asserts #(
    parameter int MEAS_W = 11
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire fcr_pkg::fcr_cmd_t i_cmd,
    input wire logic i_clear_faults,
    input wire logic i_enable_pin,
    input wire logic [10:0] i_temp_half_deg,
    input wire logic [10:0] i_ot_warn_mant,
    input wire logic signed [MEAS_W-1:0] i_iout_raw,
    input wire fcr_pkg::fcr_resp_t o_resp,
    input wire logic o_output_on,
    input wire logic o_alert_n,
    input wire logic [7:0] o_status_byte,
    input wire logic [7:0] o_status_cml,
    input wire logic [7:0] o_status_temp,
    input wire logic signed [MEAS_W:0] o_iout_corrected
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    logic wr;
    logic rd;
    assign wr = i_cmd.valid && i_cmd.write;
    assign rd = i_cmd.valid && !i_cmd.write;
    sequence s_refused;
        o_resp.valid && o_resp.nack;
    endsequence
    sequence s_cml_flagged;
        o_status_cml[6] && o_status_byte[1];
    endsequence
    chk_read_allowed: assert property (rd && i_cmd.code inside {8'h01, 8'h02, 8'h10, 8'h39, 8'h4F}
        |=> o_resp.valid && !o_resp.nack) else $error("supported read refused");
    chk_mask_unreadable: assert property (rd && i_cmd.code == 8'h1B |=> s_refused)
        else $error("mask register read not refused");
    chk_off_beh_zero: assert property (rd && i_cmd.code == 8'h01 |=> !o_resp.data[6])
        else $error("off behaviour bit not zero");
    chk_cfg_fixed_ones: assert property (rd && i_cmd.code == 8'h02 |=> o_resp.data[1:0] == 2'h3)
        else $error("fixed config bits not one");
    chk_cfg_zero_bad: assert property (wr && i_cmd.code == 8'h02 && (i_cmd.data[4:0] & 5'h13) != 5'h13
        |=> s_refused ##1 s_cml_flagged) else $error("config zero write not flagged");
    chk_wp_undefined: assert property (wr && i_cmd.code == 8'h10 && i_cmd.data[7:5] inside {3'h3, 3'h5, 3'h6, 3'h7}
        |=> s_refused) else $error("undefined protect level accepted");
    chk_cal_bounds: assert property (wr && i_cmd.code == 8'h39 && (i_cmd.data[15:11] != 5'h1D
        || $signed(i_cmd.data[10:0]) > 11'sh010 || $signed(i_cmd.data[10:0]) < -11'sh010) |=> s_refused)
        else $error("bad calibration offset accepted");
    chk_ot_exponent: assert property (wr && i_cmd.code == 8'h4F && i_cmd.data[15:11] != 5'h1F
        |=> s_refused) else $error("bad fault limit exponent accepted");
    chk_ot_above_warn: assert property (wr && i_cmd.code == 8'h4F && i_cmd.data[10:0] <= i_ot_warn_mant
        |=> s_refused) else $error("fault limit not above warning accepted");
    chk_alert_has_cause: assert property (!o_alert_n |-> o_status_byte[2:1] != 2'h0
        || o_status_cml[6] || o_status_temp[7]) else $error("alert low without a flag");
    chk_ot_shuts_off: assert property (o_status_temp[7] |-> !o_output_on)
        else $error("output on during over-temperature fault");
    chk_ot_status_pair: assert property ($rose(o_status_temp[7]) |-> o_status_byte[2])
        else $error("temperature summary bit missing");
endmodule : fcr_bank_asserts
`default_nettype wire

// ==== testbench/fcr_bank_tb.sv ====
// Self-checking testbench for the fuse control register bank.
// Assumes fcr_pkg, fcr_bank, fcr_host and fcr_bank_asserts are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fcr_bank_tb;
    logic i_clock, i_sys_rst, i_clear_faults, i_enable_pin, ok, nack;
    logic [10:0] i_temp_half_deg, i_ot_warn_mant, warn;
    logic signed [10:0] i_iout_raw;
    fcr_pkg::fcr_cmd_t i_cmd;
    fcr_pkg::fcr_resp_t o_resp;
    logic o_output_on, o_alert_n;
    logic [7:0] o_status_byte, o_status_cml, o_status_temp, m;
    logic signed [11:0] o_iout_corrected;
    logic [15:0] rdata;
    logic [2:0] lv;
    int num_errors, checks, raw, mant;
    logic [7:0] tgt [7] = '{8'h78, 8'h79, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
    logic [7:0] bad [7] = '{fcr_pkg::UNSUP_BYTE, fcr_pkg::UNSUP_WORD, fcr_pkg::UNSUP_IOUT,
        fcr_pkg::UNSUP_INPUT, fcr_pkg::UNSUP_TEMP, fcr_pkg::UNSUP_CML, fcr_pkg::UNSUP_MFR};
    fcr_bank #(.MEAS_W(11)) uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd),
        .i_clear_faults(i_clear_faults), .i_enable_pin(i_enable_pin),
        .i_temp_half_deg(i_temp_half_deg), .i_ot_warn_mant(i_ot_warn_mant),
        .i_iout_raw(i_iout_raw), .o_resp(o_resp), .o_output_on(o_output_on),
        .o_alert_n(o_alert_n), .o_status_byte(o_status_byte), .o_status_cml(o_status_cml),
        .o_status_temp(o_status_temp), .o_iout_corrected(o_iout_corrected));
    fcr_host host (.i_clock(i_clock), .i_resp(o_resp), .o_cmd(i_cmd));
    initial begin
        i_clock = 1'h0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       input logic exp_nack, input logic [15:0] exp_data);
        host.xfer(wr, code, data, ok, nack, rdata);
        check({15'h0, ok}, 16'h1, "response");
        check({15'h0, nack}, {15'h0, exp_nack}, "refusal");
        check(rdata, exp_data, "read data");
    endtask : cmd
    task automatic flags(input logic [2:0] e);
        check({13'h0, o_status_cml[6], o_status_byte[1], o_alert_n}, {13'h0, e}, "flags");
    endtask : flags
    task automatic out_is(input logic e);
        check({15'h0, o_output_on}, {15'h0, e}, "output");
    endtask : out_is
    task automatic drive_pin(input logic v);
        @(posedge i_clock);
        i_enable_pin <= v;
        @(posedge i_clock);
        #1;
    endtask : drive_pin
    task automatic clear_flags();
        @(posedge i_clock);
        i_clear_faults <= 1'h1;
        @(posedge i_clock);
        i_clear_faults <= 1'h0;
        @(posedge i_clock);
        #1;
        flags(3'h1);
    endtask : clear_flags
    // Protection levels: the protect register itself is always writable.
    function automatic logic wp_allows(input logic [2:0] lvl, input logic [7:0] code);
        case (lvl)
            3'h0: return 1'h1;
            3'h1: return code inside {8'h10, 8'h01, 8'h02};
            3'h2: return code inside {8'h10, 8'h01};
            default: return code == 8'h10;
        endcase
    endfunction : wp_allows
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        complete_run();
    end
    initial begin
        i_sys_rst = 1'h1;
        i_clear_faults = 1'h0;
        i_enable_pin = 1'h0;
        i_temp_half_deg = 11'h0;
        i_ot_warn_mant = 11'h0F0;
        i_iout_raw = 11'sh0;
        void'($urandom(53700));
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'h0;
        cmd(1'h0, 8'h01, 16'h0, 1'h0, 16'h0000);
        cmd(1'h0, 8'h02, 16'h0, 1'h0, 16'h0017);
        cmd(1'h0, 8'h39, 16'h0, 1'h0, 16'hE800);
        cmd(1'h0, 8'h4F, 16'h0, 1'h0, 16'hF918);
        cmd(1'h0, 8'h1B, 16'h0, 1'h1, 16'h0000);
        end_test("reset values");
        drive_pin(1'h1);
        out_is(1'h1);
        cmd(1'h1, 8'h01, 16'h0000, 1'h0, 16'h0);
        out_is(1'h1);
        drive_pin(1'h0);
        out_is(1'h0);
        cmd(1'h1, 8'h02, 16'h001B, 1'h0, 16'h0);
        cmd(1'h1, 8'h01, 16'h0080, 1'h0, 16'h0);
        out_is(1'h1);
        cmd(1'h1, 8'h02, 16'h001F, 1'h0, 16'h0);
        out_is(1'h0);
        drive_pin(1'h1);
        out_is(1'h1);
        cmd(1'h1, 8'h01, 16'h0000, 1'h0, 16'h0);
        out_is(1'h0);
        // The off bit is registered from the output, so it follows one cycle later.
        @(posedge i_clock);
        #1;
        check({15'h0, o_status_byte[6]}, 16'h1, "off bit");
        cmd(1'h1, 8'h02, 16'h000F, 1'h1, 16'h0);
        flags(3'h6);
        cmd(1'h0, 8'h02, 16'h0, 1'h0, 16'h001F);
        clear_flags();
        end_test("enable modes");
        for (int l = 0; l < 8; l++) begin
            // A refused level leaves the previous level, which is always 000 here.
            lv = (l inside {0, 1, 2, 4}) ? 3'(l) : 3'h0;
            cmd(1'h1, 8'h10, {8'h0, 3'(l), 5'h0}, !(l inside {0, 1, 2, 4}), 16'h0);
            cmd(1'h1, 8'h01, 16'h0000, !wp_allows(lv, 8'h01), 16'h0);
            cmd(1'h1, 8'h02, 16'h001F, !wp_allows(lv, 8'h02), 16'h0);
            cmd(1'h1, 8'h39, 16'hE800, !wp_allows(lv, 8'h39), 16'h0);
            cmd(1'h0, 8'h39, 16'h0, 1'h0, 16'hE800);
            cmd(1'h1, 8'h10, 16'h0000, 1'h0, 16'h0);
            clear_flags();
        end
        end_test("write protection");
        foreach (tgt[i]) begin
            m = 8'($urandom);
            cmd(1'h1, 8'h1B, host.mask_word(tgt[i], m), (m & bad[i]) != 8'h0, 16'h0);
            cmd(1'h1, 8'h1B, host.mask_word(tgt[i], ~bad[i]), 1'h0, 16'h0);
            clear_flags();
        end
        cmd(1'h1, 8'h1B, host.mask_word(8'h77, 8'h00), 1'h1, 16'h0);
        check({15'h0, o_status_byte[6]}, 16'h1, "live off");
        cmd(1'h1, 8'h02, 16'h000E, 1'h1, 16'h0);
        flags(3'h7);
        clear_flags();
        foreach (tgt[i]) cmd(1'h1, 8'h1B, host.mask_word(tgt[i], 8'h00), 1'h0, 16'h0);
        end_test("alert masks");
        repeat (6) begin
            mant = int'($urandom_range(32)) - 16;
            raw = int'($urandom_range(2000)) - 1000;
            @(posedge i_clock);
            i_iout_raw <= 11'(raw);
            cmd(1'h1, 8'h39, {5'h1D, 11'(mant)}, 1'h0, 16'h0);
            check({4'h0, o_iout_corrected}, {4'h0, 12'(raw + mant)}, "corrected");
        end
        cmd(1'h1, 8'h39, 16'hEFF0, 1'h0, 16'h0);
        cmd(1'h0, 8'h39, 16'h0, 1'h0, 16'hEFF0);
        cmd(1'h1, 8'h39, 16'hE811, 1'h1, 16'h0);
        cmd(1'h1, 8'h39, 16'hF001, 1'h1, 16'h0);
        clear_flags();
        end_test("calibration");
        warn = 11'($urandom_range(158, 140));
        @(posedge i_clock);
        i_ot_warn_mant <= warn;
        cmd(1'h1, 8'h4F, {5'h1E, 11'h0A0}, 1'h1, 16'h0);
        cmd(1'h1, 8'h4F, {5'h1F, warn}, 1'h1, 16'h0);
        cmd(1'h1, 8'h4F, 16'hF89F, 1'h1, 16'h0);
        cmd(1'h1, 8'h4F, 16'hF8A0, 1'h0, 16'h0);
        clear_flags();
        cmd(1'h1, 8'h01, 16'h0080, 1'h0, 16'h0);
        out_is(1'h1);
        @(posedge i_clock);
        i_temp_half_deg <= 11'h0A0;
        repeat (2) @(posedge i_clock);
        #1;
        out_is(1'h0);
        check({13'h0, o_status_temp[7], o_status_byte[2], o_alert_n}, 16'h6, "ot");
        @(posedge i_clock);
        i_temp_half_deg <= 11'h09F;
        clear_flags();
        out_is(1'h1);
        end_test("over-temperature");
        complete_run();
    end
endmodule : fcr_bank_tb
bind fcr_bank fcr_bank_asserts #(.MEAS_W(MEAS_W)) u_chk (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_cmd(i_cmd), .i_clear_faults(i_clear_faults),
    .i_enable_pin(i_enable_pin), .i_temp_half_deg(i_temp_half_deg),
    .i_ot_warn_mant(i_ot_warn_mant), .i_iout_raw(i_iout_raw), .o_resp(o_resp),
    .o_output_on(o_output_on), .o_alert_n(o_alert_n), .o_status_byte(o_status_byte),
    .o_status_cml(o_status_cml), .o_status_temp(o_status_temp),
    .o_iout_corrected(o_iout_corrected));
`default_nettype wire
